//--- shared/scsfe_pkg.sv
// Constants and types for the disk command front end
package scsfe_pkg;
  // Operation codes
  localparam logic [7:0] OP_TEST_READY   = 8'h00;
  localparam logic [7:0] OP_REZERO       = 8'h01;
  localparam logic [7:0] OP_REQ_SENSE    = 8'h03;
  localparam logic [7:0] OP_READ         = 8'h08;
  localparam logic [7:0] OP_READ_EXT     = 8'h28;
  localparam logic [7:0] OP_READ_BUFFER  = 8'h3C;
  // Data direction codes
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_IN   = 2'h1;
  localparam logic [1:0] DIR_OUT  = 2'h2;
  // Status byte bit positions
  localparam int ST_CHECK_BIT  = 1;
  localparam int ST_BUSY_BIT   = 3;
  localparam int ST_CONFLT_BIT = 4;
  // Sense error codes and keys
  localparam logic [7:0] ERR_NONE         = 8'h00;
  localparam logic [7:0] ERR_NO_SEEK      = 8'h02;
  localparam logic [7:0] ERR_WRITE_FAULT  = 8'h03;
  localparam logic [7:0] ERR_NOT_READY    = 8'h04;
  localparam logic [7:0] ERR_BAD_ARG      = 8'h24;
  localparam logic [7:0] ERR_IFACE        = 8'h4C;
  localparam logic [3:0] KEY_NONE         = 4'h0;
  localparam logic [3:0] KEY_NOT_READY    = 4'h2;
  localparam logic [3:0] KEY_HW           = 4'h4;
  localparam logic [3:0] KEY_ILLEGAL      = 4'h5;
  // Highest accepted logical unit
  localparam logic [2:0] LUN_MAX = 3'h1;
  // Rezero timeout in clock cycles
  localparam int unsigned REZERO_TIMEOUT_MS = 2000;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned REZERO_TIMEOUT_CYC = REZERO_TIMEOUT_MS * (CLK_HZ / 1000);
  // Sector layout defaults, in bytes
  localparam logic [7:0] DEF_CHECK_BYTES = 8'h04;
  localparam logic [7:0] ADDR_FIELD_LEN  = 8'h04;
  localparam logic [7:0] SPEED_GAP_LEN   = 8'h08;
  // Command sequencer states
  typedef enum logic [4:0] {
    CS_IDLE   = 5'b00001,
    CS_DECODE = 5'b00010,
    CS_SEEK   = 5'b00100,
    CS_WAIT   = 5'b01000,
    CS_DONE   = 5'b10000
  } scsfe_cmd_e;
  // Sector framer states
  typedef enum logic [4:0] {
    FS_IDLE = 5'b00001,
    FS_GAP  = 5'b00010,
    FS_SYNC = 5'b00100,
    FS_ADDR = 5'b01000,
    FS_DATA = 5'b10000
  } scsfe_frm_e;
endpackage

//--- rtl/scsfe_front_end.sv
// Command front end and sector framer of the disk controller
`timescale 1ns/10ps
`default_nettype none
module scsfe_front_end
  import scsfe_pkg::*;
#(
  parameter int unsigned REZERO_TIMEOUT = REZERO_TIMEOUT_CYC
) (
  input  wire logic        clock,          // System clock, 10 MHz
  input  wire logic        rst_n,          // Asynchronous reset, active low
  input  wire logic        cmd_valid,      // Command block present
  output logic             cmd_ready,      // Front end can take a command
  input  wire logic [7:0]  cmd_opcode,     // Operation code byte
  input  wire logic [2:0]  cmd_lun,        // Logical unit number
  output logic             status_valid,   // Completion status pulse
  output logic [7:0]       status_byte,    // Completion status byte
  output logic [1:0]       cmd_dir,        // Data direction of command
  output logic             xfer_start,     // Data phase request pulse
  output logic             bus_connected,  // Held on bus while executing
  output logic [7:0]       sense_code,     // Recorded error code
  output logic [3:0]       sense_key,      // Recorded sense key
  input  wire logic [1:0]  drv_ready,      // Drive ready per unit
  input  wire logic [1:0]  drv_fault,      // Drive write fault per unit
  input  wire logic [1:0]  drv_busy,       // Drive busy per unit
  input  wire logic [1:0]  drv_reserved,   // Reserved to other initiator
  input  wire logic        iface_err,      // Serial interface error
  output logic             seek_zero,      // Rezero request pulse
  input  wire logic        seek_done,      // Drive seek complete pulse
  input  wire logic        fixed_sector,   // Fixed-sector mode, else soft
  input  wire logic        use_sector_pulse, // In fixed mode, sectors from sector pulses, else from the index pulse
  input  wire logic        index_pulse,    // Drive index pulse
  input  wire logic        byte_clock,     // Drive byte clock strobe
  input  wire logic        drv_sector,     // Drive sector pulse
  input  wire logic        addr_mark,      // Address mark found
  input  wire logic [7:0]  cfg_preamble,   // Preamble bytes from drive config
  input  wire logic [7:0]  cfg_gap,        // Gap bytes from drive config
  input  wire logic        cfg_ref_unlocked, // Reference clock not speed locked
  input  wire logic [7:0]  cfg_check_bytes,  // Check bytes per field, 0 = default
  input  wire logic [15:0] data_bytes,     // Data field byte count
  output logic             sector_pulse,   // Internal sector pulse
  output logic [1:0]       frame_field,    // 0 gap,1 sync,2 addr,3 data
  output logic             id_field_active // Four-byte block address field
);

  // Decode opcode into direction; bit 2 flags a supported code
  function automatic logic [2:0] op_decode(input logic [7:0] op);
    unique case (op)
      OP_TEST_READY, OP_REZERO:             op_decode = {1'b1, DIR_NONE};
      OP_REQ_SENSE, OP_READ, OP_READ_EXT,
      OP_READ_BUFFER:                       op_decode = {1'b1, DIR_IN};
      default:                              op_decode = {1'b0, DIR_NONE};
    endcase
  endfunction

  scsfe_cmd_e  cs_q, cs_d;
  logic [7:0]  op_q, op_d;
  logic        unit_q, unit_d;
  logic [7:0]  st_q, st_d;
  logic        stv_q, stv_d;
  logic [1:0]  dir_q, dir_d;
  logic        xs_q, xs_d;
  logic        sz_q, sz_d;
  logic [7:0]  sc_q, sc_d;
  logic [3:0]  sk_q, sk_d;
  logic [31:0] to_q, to_d;
  logic [2:0]  dec;

  // Command sequencer next state
  always_comb begin
    cs_d   = cs_q;
    op_d   = op_q;
    unit_d = unit_q;
    st_d   = st_q;
    stv_d  = 1'b0;
    dir_d  = dir_q;
    xs_d   = 1'b0;
    sz_d   = 1'b0;
    sc_d   = sc_q;
    sk_d   = sk_q;
    to_d   = to_q;
    dec    = op_decode(op_q);
    unique case (cs_q)
      CS_IDLE: begin
        if (cmd_valid) begin
          op_d   = cmd_opcode;
          unit_d = cmd_lun[0];
          cs_d   = CS_DECODE;
          // Sense survives only into a directly following request sense
          if (cmd_opcode != OP_REQ_SENSE) begin
            sc_d = ERR_NONE;
            sk_d = KEY_NONE;
          end
        end
      end
      CS_DECODE: begin
        st_d  = 8'h00;
        dir_d = dec[1:0];
        cs_d  = CS_DONE;
        if (!dec[2]) begin
          st_d[ST_CHECK_BIT] = 1'b1;
          sc_d = ERR_BAD_ARG;
          sk_d = KEY_ILLEGAL;
        end else if (cmd_lun > LUN_MAX) begin
          st_d[ST_CHECK_BIT] = 1'b1;
          sc_d = ERR_BAD_ARG;
          sk_d = KEY_ILLEGAL;
        end else if (op_q == OP_REQ_SENSE) begin
          xs_d = 1'b1;
        end else if (drv_reserved[unit_q]) begin
          st_d[ST_BUSY_BIT]   = 1'b1;
          st_d[ST_CONFLT_BIT] = 1'b1;
        end else if (drv_busy[unit_q]) begin
          st_d[ST_BUSY_BIT] = 1'b1;
        end else if (iface_err || drv_fault[unit_q] || !drv_ready[unit_q]) begin
          st_d[ST_CHECK_BIT] = 1'b1;
          // Sense code and key recorded together
          if (iface_err) begin
            sc_d = ERR_IFACE;
            sk_d = KEY_HW;
          end else if (drv_fault[unit_q]) begin
            sc_d = ERR_WRITE_FAULT;
            sk_d = KEY_HW;
          end else begin
            sc_d = ERR_NOT_READY;
            sk_d = KEY_NOT_READY;
          end
        end else if (op_q == OP_REZERO) begin
          sz_d = 1'b1;
          to_d = 32'h0;
          cs_d = CS_SEEK;
        end else if (op_q != OP_TEST_READY) begin
          xs_d = 1'b1;
        end
        // Test ready: status stays zero when ready, no wait state
      end
      CS_SEEK: begin
        cs_d = CS_WAIT;
      end
      CS_WAIT: begin
        // Status held back until the actuator reaches track zero or REZERO_TIMEOUT cycles pass
        to_d = to_q + 32'h1;
        if (seek_done) begin
          cs_d = CS_DONE;
        end else if (to_q >= REZERO_TIMEOUT - 1) begin
          st_d[ST_CHECK_BIT] = 1'b1;
          sc_d = ERR_NO_SEEK;
          sk_d = KEY_HW;
          cs_d = CS_DONE;
        end
      end
      CS_DONE: begin
        stv_d = 1'b1;
        cs_d  = CS_IDLE;
      end
      default: cs_d = CS_IDLE;
    endcase
  end

  // Command sequencer registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_q   <= CS_IDLE;
      op_q   <= 8'h00;
      unit_q <= 1'b0;
      st_q   <= 8'h00;
      stv_q  <= 1'b0;
      dir_q  <= DIR_NONE;
      xs_q   <= 1'b0;
      sz_q   <= 1'b0;
      sc_q   <= ERR_NONE;
      sk_q   <= KEY_NONE;
      to_q   <= 32'h0;
    end else begin
      cs_q   <= cs_d;
      op_q   <= op_d;
      unit_q <= unit_d;
      st_q   <= st_d;
      stv_q  <= stv_d;
      dir_q  <= dir_d;
      xs_q   <= xs_d;
      sz_q   <= sz_d;
      sc_q   <= sc_d;
      sk_q   <= sk_d;
      to_q   <= to_d;
    end
  end

  // Status pulse is still part of the command; host stays on the bus
  assign cmd_ready     = (cs_q == CS_IDLE) && !stv_q;
  assign bus_connected = (cs_q != CS_IDLE) || stv_q;
  assign status_valid  = stv_q;
  assign status_byte   = st_q & 8'h1A;
  assign cmd_dir       = dir_q;
  assign xfer_start    = xs_q;
  assign seek_zero     = sz_q;
  assign sense_code    = sc_q;
  assign sense_key     = sk_q;

  // Sector framer
  scsfe_frm_e  fs_q, fs_d;
  logic [15:0] cnt_q, cnt_d;
  logic        sp_q, sp_d;
  logic        prev_q, prev_d;
  logic        src, bstep, start;
  logic [7:0]  chk;
  logic [15:0] gap_len, addr_len;

  // Field lengths; counts are minimums except the exact address field
  always_comb begin
    src      = use_sector_pulse ? drv_sector : index_pulse;
    chk      = (cfg_check_bytes == 8'h00) ? DEF_CHECK_BYTES : cfg_check_bytes;
    gap_len  = {8'h00, cfg_gap} + (cfg_ref_unlocked ? {8'h00, SPEED_GAP_LEN} : 16'h0);
    addr_len = {8'h00, ADDR_FIELD_LEN} + {8'h00, chk};
    bstep    = fixed_sector ? byte_clock : 1'b1;
    start    = fixed_sector ? (src && !prev_q) : addr_mark;
  end

  // Framer next state
  always_comb begin
    fs_d   = fs_q;
    cnt_d  = cnt_q;
    prev_d = src;
    sp_d   = fixed_sector && use_sector_pulse && drv_sector && !prev_q;
    if (start) begin
      fs_d  = fixed_sector ? FS_GAP : FS_ADDR;
      cnt_d = 16'h0;
    end else if (bstep) begin
      cnt_d = cnt_q + 16'h1;
      unique case (fs_q)
        FS_IDLE: cnt_d = 16'h0;
        // Compare count plus one so a zero length cannot wrap to all ones
        FS_GAP: if (cnt_q + 16'h1 >= gap_len) begin
          fs_d  = FS_SYNC;
          cnt_d = 16'h0;
        end
        FS_SYNC: if (cnt_q + 16'h1 >= {8'h00, cfg_preamble}) begin
          fs_d  = FS_ADDR;
          cnt_d = 16'h0;
        end
        FS_ADDR: if (cnt_q == addr_len - 16'h1) begin
          fs_d  = FS_DATA;
          cnt_d = 16'h0;
        end
        FS_DATA: if (cnt_q >= data_bytes + {8'h00, chk} - 16'h1) begin
          fs_d  = FS_IDLE;
          cnt_d = 16'h0;
        end
        default: fs_d = FS_IDLE;
      endcase
    end
  end

  // Framer registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fs_q   <= FS_IDLE;
      cnt_q  <= 16'h0;
      sp_q   <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      fs_q   <= fs_d;
      cnt_q  <= cnt_d;
      sp_q   <= sp_d;
      prev_q <= prev_d;
    end
  end

  assign sector_pulse    = sp_q;
  assign frame_field     = (fs_q == FS_SYNC) ? 2'h1 :
                           (fs_q == FS_ADDR) ? 2'h2 :
                           (fs_q == FS_DATA) ? 2'h3 : 2'h0;
  assign id_field_active = (fs_q == FS_ADDR) && (cnt_q < {8'h00, ADDR_FIELD_LEN});
endmodule
`default_nettype wire

//--- dv/scsfe_checker.sv
// Port-level property checker for the disk command front end
`timescale 1ns/10ps
`default_nettype none
module scsfe_checker
  import scsfe_pkg::*;
#(
  parameter int unsigned REZERO_TIMEOUT = REZERO_TIMEOUT_CYC
) (
  input wire logic       clock,            // Clock
  input wire logic       rst_n,            // Reset, active low
  input wire logic       cmd_valid,        // Command offered
  input wire logic       cmd_ready,        // Idle
  input wire logic [7:0] cmd_opcode,       // Opcode
  input wire logic [2:0] cmd_lun,          // Unit
  input wire logic       status_valid,     // Status pulse
  input wire logic [7:0] status_byte,      // Status
  input wire logic       bus_connected,    // Connected
  input wire logic [7:0] sense_code,       // Sense code
  input wire logic [3:0] sense_key,        // Sense key
  input wire logic       seek_zero,        // Rezero request
  input wire logic       seek_done,        // Seek complete
  input wire logic       fixed_sector,     // Fixed mode
  input wire logic       use_sector_pulse, // Pulse mode
  input wire logic       drv_sector,       // Drive sector pulse
  input wire logic       sector_pulse,     // Own sector pulse
  input wire logic [1:0] frame_field,      // Framer field
  input wire logic       id_field_active   // Address field
);
  // Command accepted this edge
  wire logic take = cmd_valid && cmd_ready;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_TAKE_HOLDS: assert property (take |=> !cmd_ready && bus_connected)
    else $error("take did not hold the bus");
  AST_STATUS_DUE: assert property (take && cmd_opcode != OP_REZERO |-> ##[2:4] status_valid)
    else $error("status late");
  AST_STATUS_ON_BUS: assert property (status_valid |-> bus_connected)
    else $error("status while disconnected");
  AST_ZERO_BITS: assert property (status_valid |-> (status_byte & 8'hE5) == 8'h00)
    else $error("reserved status bit set");
  AST_CONFLT_BUSY: assert property (status_valid && status_byte[ST_CONFLT_BIT] |->
    status_byte[ST_BUSY_BIT]) else $error("conflict without busy");
  AST_CHECK_SENSE: assert property (status_valid && status_byte[ST_CHECK_BIT] |->
    sense_code != ERR_NONE && sense_key != KEY_NONE) else $error("check without sense");
  AST_BAD_LUN: assert property (take && cmd_lun > LUN_MAX |-> ##[2:4] status_valid &&
    status_byte == 8'h02 && sense_code == ERR_BAD_ARG) else $error("bad unit accepted");
  AST_SEEK_WAIT: assert property (seek_zero ##1 !seek_done [*4] |-> !status_valid)
    else $error("status before seek done");
  AST_SEEK_BOUND: assert property (seek_zero |-> ##[1:100] status_valid)
    else $error("rezero never ended");
  AST_SECTOR: assert property ($rose(drv_sector) && fixed_sector && use_sector_pulse
    |-> ##[1:2] sector_pulse) else $error("no own sector pulse");
  AST_ID_AREA: assert property (id_field_active |-> frame_field == 2'h2)
    else $error("id field outside address area");
endmodule
bind scsfe_front_end scsfe_checker #(.REZERO_TIMEOUT(REZERO_TIMEOUT)) u_chk (.clock, .rst_n,
  .cmd_valid, .cmd_ready, .cmd_opcode, .cmd_lun, .status_valid, .status_byte, .bus_connected,
  .sense_code, .sense_key, .seek_zero, .seek_done, .fixed_sector, .use_sector_pulse,
  .drv_sector, .sector_pulse, .frame_field, .id_field_active);
`default_nettype wire

//--- dv/scsfe_drive_model.sv
// Drive-side model: seek answers and rotation pulses
`timescale 1ns/10ps
`default_nettype none
module scsfe_drive_model (
  input  wire logic clock,       // Clock
  input  wire logic rst_n,       // Reset, active low
  input  wire logic seek_zero,   // Rezero request
  input  wire logic slow,        // Long seek
  input  wire logic mute,        // Never answer
  output logic      seek_done,   // Seek complete pulse
  output logic      index_pulse, // Track start
  output logic      byte_clock,  // Byte strobe
  output logic      drv_sector,  // Sector pulse
  output logic      addr_mark    // Unused in fixed mode
);
  int         seek_cnt;
  logic [7:0] pos;
  // Seek timer and rotation; a muted drive models a stuck actuator
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seek_cnt <= 0;
      pos <= 8'h00;
      seek_done <= 1'b0;
    end else begin
      pos <= pos + 8'h01;
      seek_done <= (seek_cnt == 1);
      if (seek_zero) seek_cnt <= mute ? 0 : (slow ? 20 : 3);
      else if (seek_cnt != 0) seek_cnt <= seek_cnt - 1;
    end
  end
  // Pulses decoded from the rotation position
  assign byte_clock = pos[0];
  assign drv_sector = (pos[5:0] == 6'h3F);
  assign index_pulse = (pos == 8'hFF);
  assign addr_mark = 1'b0;
endmodule
`default_nettype wire

//--- dv/test_scsi_disk_command_front_end.sv
// Self-checking bench for the disk command front end
`timescale 1ns/10ps
`default_nettype none
module test_scsi_disk_command_front_end;
  import scsfe_pkg::*;
  logic        clock, rst_n, cmd_valid, cmd_ready, status_valid, xfer_start, bus_connected;
  logic        iface_err, seek_zero, seek_done, fixed_sector, use_sector_pulse, index_pulse;
  logic        byte_clock, drv_sector, addr_mark, cfg_ref_unlocked, sector_pulse;
  logic        id_field_active, slow, mute;
  logic [7:0]  cmd_opcode, status_byte, sense_code, cfg_preamble, cfg_gap, cfg_check_bytes;
  logic [7:0]  last_c;
  logic [2:0]  cmd_lun;
  logic [1:0]  cmd_dir, drv_ready, drv_fault, drv_busy, drv_reserved, frame_field;
  logic [3:0]  sense_key, last_k;
  logic [15:0] data_bytes;
  logic [21:0] exp_q[$];
  logic [21:0] mon_e;
  logic        xs_seen = 1'b0;
  logic [7:0]  ops [9] = '{OP_TEST_READY, OP_REZERO, OP_REQ_SENSE, OP_READ, OP_READ_EXT,
                            OP_READ_BUFFER, 8'h04, 8'h2A, 8'hFF};
  int          errors, cmp_count, seed;

  scsfe_front_end #(.REZERO_TIMEOUT(50)) u_dut (.clock, .rst_n, .cmd_valid, .cmd_ready,
    .cmd_opcode, .cmd_lun, .status_valid, .status_byte, .cmd_dir, .xfer_start, .bus_connected,
    .sense_code, .sense_key, .drv_ready, .drv_fault, .drv_busy, .drv_reserved, .iface_err,
    .seek_zero, .seek_done, .fixed_sector, .use_sector_pulse, .index_pulse, .byte_clock,
    .drv_sector, .addr_mark, .cfg_preamble, .cfg_gap, .cfg_ref_unlocked, .cfg_check_bytes,
    .data_bytes, .sector_pulse, .frame_field, .id_field_active);
  scsfe_drive_model u_drv (.clock, .rst_n, .seek_zero, .slow, .mute, .seek_done,
    .index_pulse, .byte_clock, .drv_sector, .addr_mark);

  // Clock, 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop();
    if (errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Drive levels settle one edge before the next command
  task automatic setst(input logic [1:0] r, f, b, v, input logic ie);
    {drv_ready, drv_fault, drv_busy, drv_reserved, iface_err} <= {r, f, b, v, ie};
    @(posedge clock);
  endtask

  // Notes the expected answer, offers the command, waits for idle
  task automatic send(input logic [7:0] op, input logic [2:0] lun);
    logic [7:0] st, c;
    logic [3:0] k;
    logic [1:0] d;
    logic       u;
    int         n;
    {u, st, c, k, d, n} = {lun[0], 8'h00, ERR_NONE, KEY_NONE, DIR_NONE, 32'd0};
    if (!(op inside {OP_TEST_READY, OP_REZERO, OP_REQ_SENSE, OP_READ, OP_READ_EXT,
                     OP_READ_BUFFER}) || lun > LUN_MAX)
      {st, c, k} = {8'h02, ERR_BAD_ARG, KEY_ILLEGAL};
    else if (op == OP_REQ_SENSE) {d, c, k} = {DIR_IN, last_c, last_k};
    else if (drv_reserved[u]) st = 8'h18;
    else if (drv_busy[u]) st = 8'h08;
    else if (iface_err) {st, c, k} = {8'h02, ERR_IFACE, KEY_HW};
    else if (drv_fault[u]) {st, c, k} = {8'h02, ERR_WRITE_FAULT, KEY_HW};
    else if (!drv_ready[u]) {st, c, k} = {8'h02, ERR_NOT_READY, KEY_NOT_READY};
    else if (op == OP_REZERO && mute) {st, c, k} = {8'h02, ERR_NO_SEEK, KEY_HW};
    else if (op != OP_TEST_READY && op != OP_REZERO) d = DIR_IN;
    {last_c, last_k} = {c, k};
    exp_q.push_back({d, st, c, k});
    {cmd_opcode, cmd_lun, cmd_valid} <= {op, lun, 1'b1};
    @(posedge clock);
    cmd_valid <= 1'b0;
    do @(posedge clock); while (cmd_ready !== 1'b1 && ++n < 200);
    if (n >= 200) errors++;
  endtask

  // Byte-clock framing: measures one address field after the next index
  task automatic frame_check();
    int na, ni;
    na = 0;
    ni = 0;
    @(posedge clock iff index_pulse === 1'b1);
    @(posedge clock iff frame_field === 2'h2);
    while (frame_field === 2'h2) begin
      na++;
      if (id_field_active === 1'b1) ni++;
      @(posedge clock);
    end
    chk(8'(na), 8'(2 * (ADDR_FIELD_LEN + DEF_CHECK_BYTES)));
    chk(8'(ni), 8'(2 * ADDR_FIELD_LEN));
  endtask

  // Takes the oldest note at each status pulse
  always @(posedge clock) begin
    if (xfer_start === 1'b1) xs_seen = 1'b1;
    if (status_valid === 1'b1) begin
      mon_e = exp_q.pop_front();
      chk({7'h0, xs_seen}, {7'h0, mon_e[21:20] == DIR_IN});
      xs_seen = 1'b0;
      chk(status_byte, mon_e[19:12]);
      chk(sense_code, mon_e[11:4]);
      chk({4'h0, sense_key}, {4'h0, mon_e[3:0]});
      if (mon_e[19:12] == 8'h00) chk({6'h0, cmd_dir}, {6'h0, mon_e[21:20]});
    end
  end

  // Main sequence
  initial begin
    {errors, cmp_count, seed, rst_n, last_c, last_k} = {64'd0, 32'hc2deab30, 13'h0};
    {cmd_valid, cmd_opcode, cmd_lun, iface_err, drv_fault, drv_busy, drv_reserved} = '0;
    {slow, mute, drv_ready, fixed_sector, use_sector_pulse} = 6'h0F;
    cfg_preamble = 8'($random(seed));
    cfg_gap = 8'($random(seed));
    cfg_check_bytes = {6'h00, 2'($random(seed))};
    cfg_ref_unlocked = 1'($random(seed));
    data_bytes = {8'h00, 8'($random(seed))};
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (ops[i]) send(ops[i], {2'h0, 1'($random(seed))});
    send(OP_TEST_READY, 3'h2);
    send(OP_READ, 3'h7);
    setst(2'h3, 2'h0, 2'h2, 2'h1, 1'b0);
    send(OP_TEST_READY, 3'h1);
    send(OP_TEST_READY, 3'h0);
    setst(2'h3, 2'h0, 2'h0, 2'h0, 1'b1);
    send(OP_TEST_READY, 3'h0);
    send(OP_REQ_SENSE, 3'h0);
    setst(2'h1, 2'h1, 2'h0, 2'h0, 1'b0);
    send(OP_TEST_READY, 3'h0);
    send(OP_READ, 3'h1);
    send(OP_REQ_SENSE, 3'h1);
    setst(2'h3, 2'h0, 2'h0, 2'h0, 1'b0);
    slow <= 1'b1;
    @(posedge clock);
    send(OP_REZERO, 3'h0);
    mute <= 1'b1;
    @(posedge clock);
    send(OP_REZERO, 3'h1);
    {use_sector_pulse, cfg_gap, cfg_preamble, cfg_ref_unlocked, cfg_check_bytes, data_bytes}
      <= {1'b0, 8'h02, 8'h02, 1'b0, 8'h00, 16'h0004};
    frame_check();
    repeat (5) @(posedge clock);
    if (exp_q.size() != 0) errors++;
    report_and_stop();
  end

  // Watchdog well beyond the expected run
  initial begin
    #(100 * 5000);
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
